// ---- shared/acrs_regs.vh ----
`ifndef ACRS_REGS_VH
`define ACRS_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define ACRS_OFS_RES_LOW     8'h00
`define ACRS_OFS_RES_HIGH    8'h04
`define ACRS_OFS_CONTROL     8'h08
`define ACRS_OFS_STATUS      8'h0C
`define ACRS_OFS_SELECT      8'h10
`define ACRS_OFS_MASK        8'h14

// ****************************************
// channel_reference_select fields
// ****************************************
`define ACRS_SEL_RESERVED    7
`define ACRS_SEL_REF         6
`define ACRS_SEL_TOUCH_A     5
`define ACRS_SEL_TOUCH_B     4
`define ACRS_SEL_CHAN_HI     3
`define ACRS_SEL_CHAN_LO     0
`define ACRS_SEL_WMASK       8'h7F
`define ACRS_SEL_RESET       8'h00

// ****************************************
// channel codes
// ****************************************
`define ACRS_CHAN_GROUND     4'h8
`define ACRS_CHAN_BANDGAP    4'h9
`define ACRS_CHAN_TEMP       4'hA

// ****************************************
// control, status and mask fields
// ****************************************
`define ACRS_CTL_ENABLE      0
`define ACRS_CTL_START       1
`define ACRS_CTL_LEFT        2
`define ACRS_CTL_RESET       3'h0
`define ACRS_STS_DONE        0
`define ACRS_STS_RESET       1'h0
`define ACRS_MASK_RESET      1'h0

// ****************************************
// timing counts and result code limits
// ****************************************
`define ACRS_CONV_NORMAL     5'h0D
`define ACRS_CONV_LONG       5'h19
`define ACRS_CLK_DIV         4'h8
`define ACRS_CODE_ZERO       10'h000
`define ACRS_CODE_FULL       10'h3FF

`endif

// ---- hw/acrs_conv_seq.v ----
`timescale 1ns/1ps
`include "acrs_regs.vh"

module acrs_conv_seq
(
   input  wire       clk_i,
   input  wire       srst_i,
   input  wire       ce_i,
   input  wire       tick_i,
   input  wire       start_i,
   input  wire       long_i,
   input  wire       abort_i,
   output wire       busy_o,
   output wire       last_o,
   output wire       done_o
);

   reg         busy_q;
   reg  [4:0]  cnt_q;
   reg  [4:0]  len_q;

   // ****************************************
   // converter cycle counter
   // ****************************************
   assign busy_o = busy_q;
   assign last_o = busy_q && (cnt_q == len_q - 5'h01);
   assign done_o = last_o && tick_i && !abort_i;

   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         busy_q <= 1'b0;
         cnt_q  <= 5'h00;
         len_q  <= `ACRS_CONV_NORMAL;
      end
      else if (ce_i)
      begin
         if (abort_i)
         begin
            busy_q <= 1'b0;
            cnt_q  <= 5'h00;
         end
         else if (!busy_q)
         begin
            if (start_i && tick_i)
            begin
               busy_q <= 1'b1;
               cnt_q  <= 5'h00;
               len_q  <= long_i ? `ACRS_CONV_LONG : `ACRS_CONV_NORMAL;
            end
         end
         else if (tick_i)
         begin
            if (last_o)
            begin
               busy_q <= 1'b0;
               cnt_q  <= 5'h00;
            end
            else
            begin
               cnt_q <= cnt_q + 5'h01;
            end
         end
      end
   end

endmodule

// ---- hw/acrs_top.v ----
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "acrs_regs.vh"

// Functional notes
// - result is an unsigned 10-bit code, zero is ground, all ones full scale
// - after completion the code is readable through low and high result bytes
// - channel code 1010 routes and enables the temperature sensor
// - top bit of the selection register always reads zero
// - reference bit clear selects supply, set selects internal reference
// - reference change during a conversion waits until that conversion completes
// - conversion after a reference change takes 25 converter cycles
// - codes 0-7 external inputs, 8 ground, 9 internal reference, 10 temperature, rest reserved
// - channel change during a conversion waits until that conversion completes
// - every completion sets the done flag; the result is written only when not frozen
// - selection passes via a copy locked during conversion, free in last cycle
// - reading the low byte freezes results until the high byte is read
// - left-justify setting picks left or right aligned result presentation
module acrs_top
(
   input  wire        clk_i,
   input  wire        srst_i,
   input  wire        ce_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [7:0]  paddr_i,
   input  wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire        pready_o,
   output wire        pslverr_o,
   input  wire [9:0]  conv_code_i,
   output wire [3:0]  input_channel_o,
   output wire        reference_internal_o,
   output wire        temperature_channel_en_o,
   output wire        conv_enable_o,
   output wire        conv_busy_o,
   output wire        conv_tick_o,
   output wire        irq_o
);

   // ****************************************
   // state
   // ****************************************
   reg  [7:0]  sel_q;
   reg  [7:0]  applied_q;
   reg  [2:0]  ctl_q;
   reg         start_pend_q;
   reg         first_q;
   reg         ref_changed_q;
   reg  [9:0]  result_q;
   reg         freeze_q;
   reg         done_flag_q;
   reg         mask_q;
   reg  [3:0]  div_q;
   reg  [31:0] prdata_q;
   reg         pslverr_q;

   wire        setup_w;
   wire        access_w;
   wire        wr_w;
   wire        rd_w;
   wire        tick_w;
   wire        busy_w;
   wire        last_w;
   wire        done_w;
   wire        long_w;
   wire        start_w;
   wire        abort_w;
   wire [15:0] present_w;

   reg  [31:0] rdmux_d;
   reg         hit_d;

   // ****************************************
   // helpers
   // ****************************************
   function [15:0] acrs_present;
      input [9:0] code;
      input       left;
      begin
         if (left)
         begin
            acrs_present = {code, 6'h00};
         end
         else
         begin
            acrs_present = {6'h00, code};
         end
      end
   endfunction

   function acrs_mapped;
      input [7:0] addr;
      begin
         case (addr)
            `ACRS_OFS_RES_LOW:  acrs_mapped = 1'b1;
            `ACRS_OFS_RES_HIGH: acrs_mapped = 1'b1;
            `ACRS_OFS_CONTROL:  acrs_mapped = 1'b1;
            `ACRS_OFS_STATUS:   acrs_mapped = 1'b1;
            `ACRS_OFS_SELECT:   acrs_mapped = 1'b1;
            `ACRS_OFS_MASK:     acrs_mapped = 1'b1;
            default:            acrs_mapped = 1'b0;
         endcase
      end
   endfunction

   // ****************************************
   // apb slave
   // ****************************************
   // zero wait states; read data is caught in the setup cycle
   assign setup_w   = psel_i && !penable_i;
   assign access_w  = psel_i && penable_i && ce_i;
   assign wr_w      = access_w && pwrite_i && acrs_mapped(paddr_i);
   assign rd_w      = access_w && !pwrite_i && acrs_mapped(paddr_i);
   assign pready_o  = 1'b1;
   assign prdata_o  = prdata_q;
   assign pslverr_o = pslverr_q && psel_i && penable_i;

   assign present_w = acrs_present(result_q, ctl_q[`ACRS_CTL_LEFT]);

   always @*
   begin
      rdmux_d = 32'h0000_0000;
      hit_d   = acrs_mapped(paddr_i);
      case (paddr_i)
         `ACRS_OFS_RES_LOW:
            rdmux_d = {24'h00_0000, present_w[7:0]};
         `ACRS_OFS_RES_HIGH:
            rdmux_d = {24'h00_0000, present_w[15:8]};
         `ACRS_OFS_CONTROL:
            rdmux_d = {29'h0000_0000, ctl_q[`ACRS_CTL_LEFT],
                       busy_w || start_pend_q, ctl_q[`ACRS_CTL_ENABLE]};
         `ACRS_OFS_STATUS:
            rdmux_d = {31'h0000_0000, done_flag_q};
         `ACRS_OFS_SELECT:
            rdmux_d = {24'h00_0000, 1'b0, sel_q[6:0]};
         `ACRS_OFS_MASK:
            rdmux_d = {31'h0000_0000, mask_q};
         default:
            rdmux_d = 32'h0000_0000;
      endcase
   end

   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
      else if (ce_i && setup_w)
      begin
         prdata_q  <= pwrite_i ? 32'h0000_0000 : rdmux_d;
         pslverr_q <= !hit_d;
      end
   end

   // ****************************************
   // software registers
   // ****************************************
   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         sel_q  <= `ACRS_SEL_RESET;
         ctl_q  <= `ACRS_CTL_RESET;
         mask_q <= `ACRS_MASK_RESET;
      end
      else if (ce_i && wr_w)
      begin
         case (paddr_i)
            `ACRS_OFS_SELECT:
               sel_q <= pwdata_i[7:0] & `ACRS_SEL_WMASK;
            `ACRS_OFS_CONTROL:
            begin
               ctl_q[`ACRS_CTL_ENABLE] <= pwdata_i[`ACRS_CTL_ENABLE];
               ctl_q[`ACRS_CTL_LEFT]   <= pwdata_i[`ACRS_CTL_LEFT];
            end
            `ACRS_OFS_MASK:
               mask_q <= pwdata_i[0];
            default:
               mask_q <= mask_q;
         endcase
      end
   end

   // ****************************************
   // converter clock and sequencing
   // ****************************************
   // fixed divide; the prescaler proper lives elsewhere
   assign tick_w  = ce_i && (div_q == `ACRS_CLK_DIV - 4'h1);
   assign abort_w = !ctl_q[`ACRS_CTL_ENABLE];
   assign start_w = start_pend_q && ctl_q[`ACRS_CTL_ENABLE];
   // first conversion or new reference runs long
   assign long_w  = first_q || ref_changed_q ||
                    (sel_q[`ACRS_SEL_REF] != applied_q[`ACRS_SEL_REF]);

   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         div_q <= 4'h0;
      end
      else if (ce_i)
      begin
         if (tick_w)
         begin
            div_q <= 4'h0;
         end
         else
         begin
            div_q <= div_q + 4'h1;
         end
      end
   end

   acrs_conv_seq u_seq
   (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .ce_i    (ce_i),
      .tick_i  (tick_w),
      .start_i (start_w),
      .long_i  (long_w),
      .abort_i (abort_w),
      .busy_o  (busy_w),
      .last_o  (last_w),
      .done_o  (done_w)
   );

   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         start_pend_q  <= 1'b0;
         first_q       <= 1'b1;
         ref_changed_q <= 1'b0;
      end
      else if (ce_i)
      begin
         // start may come in the same write that enables
         if (wr_w && paddr_i == `ACRS_OFS_CONTROL && pwdata_i[`ACRS_CTL_START] && pwdata_i[`ACRS_CTL_ENABLE])
         begin
            start_pend_q <= 1'b1;
         end
         else if (abort_w)
         begin
            start_pend_q <= 1'b0;
            first_q      <= 1'b1;
         end
         else if (start_w && tick_w && !busy_w)
         begin
            start_pend_q <= 1'b0;
            first_q      <= 1'b0;
         end
         if (start_w && tick_w && !busy_w)
         begin
            ref_changed_q <= 1'b0;
         end
         else if ((!busy_w || last_w) && sel_q[`ACRS_SEL_REF] != applied_q[`ACRS_SEL_REF])
         begin
            ref_changed_q <= 1'b1;
         end
      end
   end

   // ****************************************
   // applied selection copy
   // ****************************************
   // locked while busy except in the last converter cycle, when the analog path may move
   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         applied_q <= `ACRS_SEL_RESET;
      end
      // copy runs when idle or in last cycle
      else if (ce_i && (!busy_w || last_w))
      begin
         applied_q <= sel_q;
      end
   end

   // channel code drives the analog mux
   assign input_channel_o          = applied_q[`ACRS_SEL_CHAN_HI:`ACRS_SEL_CHAN_LO];
   assign reference_internal_o     = applied_q[`ACRS_SEL_REF];
   assign temperature_channel_en_o = (input_channel_o == `ACRS_CHAN_TEMP);
   assign conv_enable_o            = ctl_q[`ACRS_CTL_ENABLE];
   assign conv_busy_o              = busy_w;
   assign conv_tick_o              = tick_w;

   // ****************************************
   // result and read freeze
   // ****************************************
   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         result_q <= `ACRS_CODE_ZERO;
         freeze_q <= 1'b0;
      end
      else if (ce_i)
      begin
         // raw 10-bit code captured at completion
         if (done_w && !freeze_q)
         begin
            result_q <= conv_code_i;
         end
         // low read locks, high read releases
         if (rd_w && paddr_i == `ACRS_OFS_RES_HIGH)
         begin
            freeze_q <= 1'b0;
         end
         else if (rd_w && paddr_i == `ACRS_OFS_RES_LOW)
         begin
            freeze_q <= 1'b1;
         end
      end
   end

   // ****************************************
   // done flag and interrupt
   // ****************************************
   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         done_flag_q <= `ACRS_STS_RESET;
      end
      else if (ce_i)
      begin
         if (done_w)
         begin
            done_flag_q <= 1'b1;
         end
         else if (wr_w && paddr_i == `ACRS_OFS_STATUS && pwdata_i[`ACRS_STS_DONE])
         begin
            done_flag_q <= 1'b0;
         end
      end
   end

   assign irq_o = done_flag_q && mask_q;

endmodule

// ---- tb/acrs_chk.sv ----
`timescale 1ns/1ps
module acrs_chk
(
   input wire        clk_i,
   input wire        srst_i,
   input wire        ce_i,
   input wire        psel_i,
   input wire        penable_i,
   input wire        pwrite_i,
   input wire [7:0]  paddr_i,
   input wire [31:0] pwdata_i,
   input wire        pslverr_o,
   input wire [3:0]  input_channel_o,
   input wire        reference_internal_o,
   input wire        temperature_channel_en_o,
   input wire        conv_enable_o,
   input wire        conv_busy_o,
   input wire        conv_tick_o,
   input wire        irq_o
);
   logic [4:0] tick_cnt_q;
   logic [1:0] wr_q;
   logic [1:0] bsy_q;
   default clocking dcb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   // two-deep history: irq may lag its cause by one register
   always @(posedge clk_i)
   begin
      wr_q <= {wr_q[0], psel_i & penable_i & pwrite_i};
      bsy_q <= {bsy_q[0], conv_busy_o};
      if (srst_i)
         tick_cnt_q <= 5'h00;
      else if (conv_tick_o)
         tick_cnt_q <= conv_busy_o ? tick_cnt_q + 5'h01 : 5'h00;
   end
   sequence sel_wr;
      psel_i && penable_i && pwrite_i && ce_i && paddr_i == 8'h10 && !conv_enable_o;
   endsequence
   sequence chan_held;
      $stable(input_channel_o) [*8];
   endsequence
   sequence ref_held;
      $stable(reference_internal_o) [*8];
   endsequence
   // ****************************************
   // assertions
   // ****************************************
   chk_temp_decode:
   assert property (temperature_channel_en_o == (input_channel_o == 4'hA)) else $error("temp enable decode wrong");
   chk_chan_locked:
   assert property ($rose(conv_busy_o) |=> chan_held) else $error("channel moved in conversion");
   chk_ref_locked:
   assert property ($rose(conv_busy_o) |=> ref_held) else $error("reference moved in conversion");
   chk_conv_len:
   assert property ($fell(conv_busy_o) && conv_enable_o |-> tick_cnt_q == 5'h0D || tick_cnt_q == 5'h19)
      else $error("conversion length wrong");
   chk_tick_gap:
   assert property (conv_tick_o |=> (!conv_tick_o) [*7]) else $error("converter tick spacing wrong");
   chk_sel_follow:
   assert property (sel_wr |=> ##1 input_channel_o == $past(pwdata_i[3:0], 2)
      && reference_internal_o == $past(pwdata_i[6], 2)) else $error("idle selection not applied");
   chk_irq_cause:
   assert property ($rose(irq_o) |-> (|wr_q) || (|bsy_q)) else $error("irq without cause");
   chk_slverr_map:
   assert property (pslverr_o |-> psel_i && penable_i && (paddr_i > 8'h14 || paddr_i[1:0] != 2'h0))
      else $error("error on mapped access");
endmodule

bind acrs_top acrs_chk u_chk
(
   .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pslverr_o(pslverr_o),
   .input_channel_o(input_channel_o), .reference_internal_o(reference_internal_o),
   .temperature_channel_en_o(temperature_channel_en_o), .conv_enable_o(conv_enable_o),
   .conv_busy_o(conv_busy_o), .conv_tick_o(conv_tick_o), .irq_o(irq_o)
);

// ---- tb/acrs_analog.sv ----
`timescale 1ns/1ps
module acrs_analog
(
   input  wire        clk_i,
   input  wire [3:0]  chan_i,
   input  wire        ref_int_i,
   input  wire        temp_en_i,
   input  wire        busy_i,
   input  wire [9:0]  level_i,
   output logic [9:0] code_o
);
   logic [9:0] live;
   always_comb
   begin
      if (chan_i == 4'h8)
         live = 10'h000;
      else if (chan_i == 4'hA && !temp_en_i)
         live = ~level_i;
      else
         live = level_i ^ {chan_i, ref_int_i, 5'h00};
   end
   always @(posedge clk_i)
      if (!busy_i)
         code_o <= live;
endmodule

// ---- tb/tb_adc_channel_reference_select.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((e) !== (g)) begin bad_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_adc_channel_reference_select;
   logic        clk_i = 1'b0;
   logic        srst_i = 1'b1;
   logic        ce_i = 1'b1;
   logic        psel_i = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i = 1'b0;
   logic [7:0]  paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [9:0]  level = 10'h000;
   logic [31:0] rd;
   logic        err;
   logic [9:0]  code;
   logic [9:0]  old;
   logic        ps6 = 1'b0;
   logic        pm6 = 1'b0;
   logic        en = 1'b0;
   logic        mk = 1'b1;
   integer      bad_count = 0;
   integer      total_checks = 0;
   integer      seed = 32'h631a;
   integer      tick_n = 0;
   integer      i;
   wire [31:0]  prdata_o;
   wire         pready_o;
   wire         pslverr_o;
   wire [9:0]   conv_code;
   wire [3:0]   input_channel_o;
   wire         reference_internal_o;
   wire         temperature_channel_en_o;
   wire         conv_enable_o;
   wire         conv_busy_o;
   wire         conv_tick_o;
   wire         irq_o;
   always #5 clk_i = ~clk_i;
   acrs_top dut
   (
      .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .conv_code_i(conv_code),
      .input_channel_o(input_channel_o), .reference_internal_o(reference_internal_o),
      .temperature_channel_en_o(temperature_channel_en_o), .conv_enable_o(conv_enable_o),
      .conv_busy_o(conv_busy_o), .conv_tick_o(conv_tick_o), .irq_o(irq_o)
   );
   acrs_analog u_analog
   (
      .clk_i(clk_i), .chan_i(input_channel_o), .ref_int_i(reference_internal_o),
      .temp_en_i(temperature_channel_en_o), .busy_i(conv_busy_o), .level_i(level), .code_o(conv_code)
   );
   // converter ticks seen while busy
   always @(posedge clk_i)
      if (conv_busy_o === 1'b1 && conv_tick_o === 1'b1)
         tick_n <= tick_n + 1;
   task end_sim;
   begin
      if (bad_count == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
   endtask
   // idle edge after each transfer keeps psel from being driven twice in one step
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
   begin
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1)
         @(posedge clk_i);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   end
   endtask
   task res_chk(input logic [9:0] c, input logic lj);
   begin
      apb(1'b0, 8'h00, 32'h0);
      `CHK("res_low", lj ? {24'h0, c[1:0], 6'h00} : {24'h0, c[7:0]}, rd)
      apb(1'b0, 8'h04, 32'h0);
      `CHK("res_high", lj ? {24'h0, c[9:2]} : {30'h0, c[9:8]}, rd)
   end
   endtask
   task conv(input logic [7:0] s, input logic [7:0] m, input logic lj);
      logic [9:0] lvl;
      logic       lng;
   begin
      lvl = $random(seed);
      level <= lvl;
      lng = !en || s[6] != ps6 || pm6 != ps6;
      apb(1'b1, 8'h10, {24'h0, s});
      tick_n = 0;
      apb(1'b1, 8'h08, {29'h0, lj, 2'b11});
      `CHK("enable", 1'b1, conv_enable_o)
      en = 1'b1;
      while (conv_busy_o !== 1'b1)
         @(posedge clk_i);
      apb(1'b1, 8'h10, {24'h0, m});
      `CHK("chan_lock", s[3:0], input_channel_o)
      `CHK("ref_lock", s[6], reference_internal_o)
      while (conv_busy_o !== 1'b0)
         @(posedge clk_i);
      `CHK("ticks", lng ? 25 : 13, tick_n)
      apb(1'b0, 8'h0C, 32'h0);
      `CHK("done", 32'h1, rd)
      `CHK("irq_set", mk, irq_o)
      apb(1'b1, 8'h0C, 32'h1);
      `CHK("irq_clr", 1'b0, irq_o)
      ps6 = s[6];
      pm6 = m[6];
      code = s[3:0] == 4'h8 ? 10'h000 : lvl ^ {s[3:0], s[6], 5'h00};
   end
   endtask
   initial
   begin
      #400000;
      bad_count++;
      end_sim;
   end
   initial
   begin
      repeat (20) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
      apb(1'b0, 8'h10, 32'h0);
      `CHK("sel_reset", 32'h0, rd)
      apb(1'b0, 8'h18, 32'h0);
      `CHK("unmapped", 1'b1, err)
      apb(1'b1, 8'h10, 32'hCF);
      apb(1'b0, 8'h10, 32'h0);
      `CHK("sel_top", 32'h4F, rd)
      for (i = 0; i < 11; i++)
      begin
         code = $random(seed);
         apb(1'b1, 8'h10, {25'h0, code[0], 2'b00, i[3:0]});
         apb(1'b0, 8'h10, 32'h0);
         `CHK("sel_back", {25'h0, code[0], 2'b00, i[3:0]}, rd)
         `CHK("chan_out", i[3:0], input_channel_o)
         `CHK("ref_out", code[0], reference_internal_o)
         `CHK("temp_en", i == 10, temperature_channel_en_o)
      end
      ce_i <= 1'b0;
      apb(1'b1, 8'h10, 32'h3);
      ce_i <= 1'b1;
      apb(1'b0, 8'h10, 32'h0);
      `CHK("ce_hold", {25'h0, code[0], 6'h0A}, rd)
      apb(1'b1, 8'h14, 32'h1);
      `CHK("irq_idle", 1'b0, irq_o)
      conv(8'h4A, 8'h03, 1'b0);
      res_chk(code, 1'b0);
      conv(8'h08, 8'h08, 1'b1);
      res_chk(code, 1'b1);
      conv(8'h05, 8'h45, 1'b0);
      res_chk(code, 1'b0);
      conv(8'h03, 8'h03, 1'b0);
      old = code;
      apb(1'b0, 8'h00, 32'h0);
      apb(1'b1, 8'h14, 32'h0);
      mk = 1'b0;
      conv(8'h01, 8'h01, 1'b0);
      apb(1'b0, 8'h04, 32'h0);
      `CHK("frozen", {30'h0, old[9:8]}, rd)
      res_chk(old, 1'b0);
      end_sim;
   end
endmodule
